// *** hw/hssc_top.sv ***
/*
  Hot-swap startup control: strap capture at bus reset release, bus mode
  selection, configuration claim gating, ejector latch, LED and the
  open-drain insertion event line, with an APB register file.
  Assumes all strap and switch pins are asynchronous to pclk and that an
  external pull-up holds the event line high while released.
*/
`default_nettype none
`include "hssc_cfg.svh"
module hssc_top #(
  parameter int unsigned DEBOUNCE_CYCLES = `HSSC_DEBOUNCE_CYC
) (
  input wire logic pclk, // APB and block clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [`HSSC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic pci_bus_rst_n, // PCI bus reset pin, active low
  input wire logic swap_startup_strap_n, // hot-swap startup strap, active low
  input wire logic [1:0] backplane_speed_strap, // backplane speed code
  input wire logic speed66_enable_pin, // 66 MHz enable pin
  input wire logic ejector_latch_state, // 0 closed, 1 open
  input wire logic [3:0] init_mode_field, // mode found by init pattern logic
  output logic insertion_event_n_o, // event line drive value, always 0
  output logic insertion_event_n_oe, // event line enable, high pulls low
  output logic swap_indicator_led, // hot-swap LED, high lights
  output logic cfg_retry_all, // retry every configuration cycle
  output logic cfg_no_claim, // leave configuration cycles unclaimed
  output logic pcix_mode, // bus runs PCI-X Mode 1
  output hssc_pkg::hssc_freq_t bus_freq, // bus frequency
  output logic irq // level interrupt
);
  localparam int unsigned NSYNC = 6;

  // two-stage synchronisers for every pin
  logic [NSYNC-1:0] pin_raw, sync1_ff, sync2_ff;
  assign pin_raw = {pci_bus_rst_n, swap_startup_strap_n, backplane_speed_strap,
                    speed66_enable_pin, ejector_latch_state};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce) begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic s_prst_n, s_strap_n, s_m66, s_latch;
  logic [1:0] s_speed;
  assign s_prst_n = sync2_ff[5];
  assign s_strap_n = sync2_ff[4];
  assign s_speed = sync2_ff[3:2];
  assign s_m66 = sync2_ff[1];
  assign s_latch = sync2_ff[0];

  // ejector switch debouncer
  hssc_db_if dbi ();
  assign dbi.raw = s_latch;

  hssc_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .db(dbi)
  );

  // latch reads 1 for an open switch
  logic latch_open, latch_opened, latch_closed;
  assign latch_open = dbi.stable;
  assign latch_opened = dbi.changed & latch_open;
  assign latch_closed = dbi.changed & ~latch_open;

  // mode lookup from speed straps; no code reaches PCI-X Mode 2
  function automatic logic [3:0] speed_mode(input logic [1:0] code);
    case (code)
      `HSSC_SPD_CONV: speed_mode = `HSSC_MODE_CONV;
      `HSSC_SPD_X66: speed_mode = `HSSC_MODE_X66;
      `HSSC_SPD_X100: speed_mode = `HSSC_MODE_X100;
      `HSSC_SPD_X133: speed_mode = `HSSC_MODE_X133;
      default: speed_mode = `HSSC_MODE_CONV;
    endcase
  endfunction

  function automatic hssc_pkg::hssc_freq_t speed_freq(input logic [1:0] code,
                                                      input logic m66);
    case (code)
      `HSSC_SPD_CONV: speed_freq = m66 ? hssc_pkg::HSSC_F66 : hssc_pkg::HSSC_F33;
      `HSSC_SPD_X66: speed_freq = hssc_pkg::HSSC_F66;
      `HSSC_SPD_X100: speed_freq = hssc_pkg::HSSC_F100;
      `HSSC_SPD_X133: speed_freq = hssc_pkg::HSSC_F133;
      default: speed_freq = hssc_pkg::HSSC_F33;
    endcase
  endfunction

  // bus reset tracking and strap capture
  hssc_pkg::hssc_state_t st_ff, nxt_st;
  logic strap_ff, nxt_strap;
  logic [3:0] mode_ff, nxt_mode;
  hssc_pkg::hssc_freq_t freq_ff, nxt_freq;
  logic cap_evt;

  // mode is held from capture on; straps may float once the bus runs
  always_comb begin
    nxt_st = st_ff;
    nxt_strap = strap_ff;
    nxt_mode = mode_ff;
    nxt_freq = freq_ff;
    cap_evt = 1'b0;
    case (st_ff)
      hssc_pkg::HSSC_ST_RST: begin
        if (s_prst_n) begin
          nxt_st = hssc_pkg::HSSC_ST_RUN;
          nxt_strap = s_strap_n;
          cap_evt = 1'b1;
          if (!s_strap_n) begin
            nxt_mode = speed_mode(s_speed);
            nxt_freq = speed_freq(s_speed, s_m66);
          end else begin
            nxt_mode = init_mode_field;
            nxt_freq = s_m66 ? hssc_pkg::HSSC_F66 : hssc_pkg::HSSC_F33;
          end
        end
      end
      hssc_pkg::HSSC_ST_RUN: begin
        if (!s_prst_n) begin
          nxt_st = hssc_pkg::HSSC_ST_RST;
        end
      end
      default: nxt_st = hssc_pkg::HSSC_ST_RST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= hssc_pkg::HSSC_ST_RST;
      strap_ff <= 1'b1;
      mode_ff <= `HSSC_MODE_CONV;
      freq_ff <= hssc_pkg::HSSC_F33;
    end else if (ce) begin
      st_ff <= nxt_st;
      strap_ff <= nxt_strap;
      mode_ff <= nxt_mode;
      freq_ff <= nxt_freq;
    end
  end

  logic hs_en;
  assign hs_en = ~strap_ff;

  // APB register file
  logic led_ff, nxt_led;
  logic retry_ff, nxt_retry;
  logic [`HSSC_IRQ_W-1:0] ist_ff, nxt_ist;
  logic [`HSSC_IRQ_W-1:0] imask_ff, nxt_imask;
  logic [`HSSC_IRQ_W-1:0] evt;
  logic wr_en, rd_en, hit;
  logic [31:0] nxt_rdata, rdata_ff;
  logic [31:0] bstat;

  assign wr_en = psel & penable & pwrite & ce;
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit = (paddr == `HSSC_OFS_CTRL) || (paddr == `HSSC_OFS_BSTAT) ||
               (paddr == `HSSC_OFS_ISTAT) || (paddr == `HSSC_OFS_IMASK);

  // insertion: latch closed at capture or later; extraction: latch opened
  // capture looks at the fresh strap, strap_ff still holds the previous one
  assign evt[`HSSC_IRQ_INS] = (cap_evt & ~s_strap_n & ~latch_open) | (hs_en & latch_closed);
  assign evt[`HSSC_IRQ_EXT] = hs_en & latch_opened;
  assign evt[`HSSC_IRQ_CAP] = cap_evt;

  always_comb begin
    bstat = `HSSC_RST_WORD;
    bstat[`HSSC_BS_STRAP] = strap_ff;
    bstat[`HSSC_BS_HSEN] = hs_en;
    bstat[`HSSC_BS_RETRY] = retry_ff;
    bstat[`HSSC_BS_LATCH] = latch_open;
    bstat[`HSSC_BS_PCIX] = pcix_mode;
    bstat[`HSSC_BS_MODE_HI:`HSSC_BS_MODE_LO] = mode_ff;
  end

  always_comb begin
    nxt_led = led_ff;
    nxt_retry = retry_ff;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    nxt_rdata = rdata_ff;
    if (wr_en) begin
      case (paddr)
        `HSSC_OFS_CTRL: nxt_led = pwdata[`HSSC_CTRL_LED];
        `HSSC_OFS_BSTAT: nxt_retry = pwdata[`HSSC_BS_RETRY];
        `HSSC_OFS_ISTAT: nxt_ist = ist_ff & ~pwdata[`HSSC_IRQ_W-1:0];
        `HSSC_OFS_IMASK: nxt_imask = pwdata[`HSSC_IRQ_W-1:0];
        default: nxt_led = led_ff;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    nxt_ist = nxt_ist | evt;
    if (rd_en) begin
      case (paddr)
        `HSSC_OFS_CTRL: nxt_rdata = {31'h0000_0000, led_ff};
        `HSSC_OFS_BSTAT: nxt_rdata = bstat;
        `HSSC_OFS_ISTAT: nxt_rdata = {29'h0000_0000, ist_ff};
        `HSSC_OFS_IMASK: nxt_rdata = {29'h0000_0000, imask_ff};
        default: nxt_rdata = `HSSC_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ff <= 1'b0;
      retry_ff <= 1'b0;
      ist_ff <= `HSSC_RST_MASK;
      imask_ff <= `HSSC_RST_MASK;
      rdata_ff <= `HSSC_RST_WORD;
    end else if (ce) begin
      led_ff <= nxt_led;
      retry_ff <= nxt_retry;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata;
    end
  end

  // zero wait states; a frozen clock enable stretches the access
  assign pready = ce;
  assign pslverr = psel & penable & ~hit;
  assign prdata = rdata_ff;
  assign irq = |(ist_ff & imask_ff);

  // configuration claim gating
  assign cfg_retry_all = retry_ff & strap_ff;
  assign cfg_no_claim = retry_ff & ~strap_ff;

  // mode and frequency outputs
  assign pcix_mode = (mode_ff != `HSSC_MODE_CONV);
  assign bus_freq = freq_ff;

  // LED follows software
  assign swap_indicator_led = led_ff;

  // event line asserted while insertion or extraction is pending and hot-swap is enabled
  assign insertion_event_n_o = 1'b0;
  assign insertion_event_n_oe = hs_en &
    (ist_ff[`HSSC_IRQ_INS] | ist_ff[`HSSC_IRQ_EXT]);
endmodule
`default_nettype wire

// *** pkg/hssc_cfg.svh ***
/*
  Constants of the hot-swap startup control block: register offsets,
  field positions, reset values, mode codes and timing.
  Assumes inclusion by bare name from the package and the design files.
*/
// Notes on behaviour
// - The insertion event line is asserted to tell the host of a fresh insertion or a pending extraction.
// - The ejector latch input reads 0 for a closed switch and 1 for an open one.
// - The indicator LED output is driven high to light the LED and low otherwise.
// - The startup strap is captured at the rising edge of the bus reset and held as the hot-swap mode.
// - A captured strap of 1 with configuration retry enabled in status bit 2 retries every configuration cycle.
// - A captured strap of 0 with retry enabled leaves configuration cycles unclaimed and takes the mode from the speed straps.
// - Hot-swap operation is enabled only when the strap is low at reset.
// - The speed straps are used only when the strap was captured as 0, and are ignored otherwise.
// - Speed code 11 gives conventional mode at 33 or 66 MHz by the 66 MHz pin and reports 1111 in bits 19:16.
// - Speed code 10 gives PCI-X Mode 1 at 66 MHz and reports 1110.
// - Speed code 01 gives PCI-X Mode 1 at 100 MHz and reports 1101.
// - Speed code 00 gives PCI-X Mode 1 at 133 MHz and reports 1100.
// - Under hot-swap the mode comes from the speed straps, not from an initialization pattern.
// - Hot-swap never selects PCI-X Mode 2; the speed codes reach conventional or Mode 1 only.
// - The ejector switch input is debounced before a change of it is acted on.
`ifndef HSSC_CFG_SVH
`define HSSC_CFG_SVH

`define HSSC_ADDR_W 12
`define HSSC_OFS_CTRL 12'h000
`define HSSC_OFS_BSTAT 12'h004
`define HSSC_OFS_ISTAT 12'h008
`define HSSC_OFS_IMASK 12'h00c

// control register
`define HSSC_CTRL_LED 0
// bus status register
`define HSSC_BS_STRAP 0
`define HSSC_BS_HSEN 1
`define HSSC_BS_RETRY 2
`define HSSC_BS_LATCH 3
`define HSSC_BS_PCIX 4
`define HSSC_BS_MODE_LO 16
`define HSSC_BS_MODE_HI 19
// interrupt status / mask
`define HSSC_IRQ_INS 0
`define HSSC_IRQ_EXT 1
`define HSSC_IRQ_CAP 2
`define HSSC_IRQ_W 3

`define HSSC_RST_WORD 32'h0000_0000
`define HSSC_RST_MASK 3'h0

`define HSSC_SPD_CONV 2'h3
`define HSSC_SPD_X66 2'h2
`define HSSC_SPD_X100 2'h1
`define HSSC_SPD_X133 2'h0
`define HSSC_MODE_CONV 4'hf
`define HSSC_MODE_X66 4'he
`define HSSC_MODE_X100 4'hd
`define HSSC_MODE_X133 4'hc

`define HSSC_CLK_MHZ 40
`define HSSC_DEBOUNCE_US 1000
`define HSSC_DEBOUNCE_CYC (`HSSC_DEBOUNCE_US * `HSSC_CLK_MHZ)

`endif

// *** pkg/hssc_pkg.sv ***
/*
  Types of the hot-swap startup control block.
  Assumes the constants header sits beside it.
*/
`default_nettype none
`include "hssc_cfg.svh"
package hssc_pkg;
  typedef enum logic [1:0] {
    HSSC_F33 = 2'h0,
    HSSC_F66 = 2'h1,
    HSSC_F100 = 2'h2,
    HSSC_F133 = 2'h3
  } hssc_freq_t;

  // one-hot: bus reset held, bus running
  typedef enum logic [1:0] {
    HSSC_ST_RST = 2'h1,
    HSSC_ST_RUN = 2'h2
  } hssc_state_t;
endpackage
`default_nettype wire

// *** pkg/hssc_db_if.sv ***
/*
  Link between the top module and its ejector switch debouncer.
  Assumes both ends share one clock.
*/
`default_nettype none
interface hssc_db_if;
  logic raw;
  logic stable;
  logic changed;
  modport deb (input raw, output stable, output changed);
  modport user (output raw, input stable, input changed);
endinterface
`default_nettype wire

// *** hw/hssc_debounce.sv ***
/*
  Ejector switch debouncer: a new level is taken only after it has held
  for CYCLES clock cycles without a break.
  Assumes raw is already synchronised to pclk.
*/
`default_nettype none
`include "hssc_cfg.svh"
module hssc_debounce #(
  parameter int unsigned CYCLES = `HSSC_DEBOUNCE_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  hssc_db_if.deb db // raw in, stable level and change pulse out
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad
    $error("debounce length must be at least one cycle");
  end

  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic stable_ff, nxt_stable;
  logic chg_ff, nxt_chg;

  // switch closes to 0 after reset, matching a board without hot-swap
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_stable = stable_ff;
    nxt_chg = 1'b0;
    if (db.raw == stable_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff == CW'(CYCLES - 1)) begin
      nxt_cnt = '0;
      nxt_stable = db.raw;
      nxt_chg = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      stable_ff <= 1'b0;
      chg_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      stable_ff <= nxt_stable;
      chg_ff <= nxt_chg;
    end
  end

  assign db.stable = stable_ff;
  assign db.changed = chg_ff & ce;
endmodule
`default_nettype wire

// *** bench/hssc_partner.sv ***
/*
  Backplane, host and ejector switch model for the hot-swap block.
  Assumes every pin change lands just after a rising edge of pclk.
*/
`default_nettype none
module hssc_partner #(
  parameter int SETTLE = 8
) (
  input wire logic pclk, // block clock
  input wire logic ev_o, // event line drive value
  input wire logic ev_oe, // event line enable
  output logic bus_rst_n, // bus reset pin
  output logic strap_n, // startup strap
  output logic [1:0] speed, // speed code
  output logic m66, // 66 MHz pin
  output logic latch, // ejector switch, 1 open
  output wire logic event_line // resolved event line
);
  timeunit 1ns;
  timeprecision 100ps;
  // released line floats up through the board pull-up
  assign event_line = ev_oe ? ev_o : 1'b1;
  initial begin
    bus_rst_n = 1'b0;
    strap_n = 1'b1;
    speed = 2'h3;
    m66 = 1'b0;
    latch = 1'b0; // closed until a scenario opens it
  end
  task automatic bus_reset(input logic s, input logic [1:0] c, input logic m);
    @(posedge pclk);
    bus_rst_n <= 1'b0;
    strap_n <= s; // settled while reset is held
    speed <= c; // only conventional or Mode 1 codes exist
    m66 <= m;
    repeat (4) @(posedge pclk);
    bus_rst_n <= 1'b1;
    repeat (SETTLE) @(posedge pclk);
  endtask
  task automatic move_latch(input logic v, input int hold);
    @(posedge pclk);
    latch <= v;
    repeat (hold) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** bench/hssc_assertions.sv ***
/*
  Port checker of the hot-swap startup control block.
  Assumes one clock domain and pins held steady around bus reset release.
*/
`default_nettype none
`include "hssc_cfg.svh"
module hssc_assertions #(
  parameter int unsigned DEBOUNCE_CYCLES = `HSSC_DEBOUNCE_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [`HSSC_ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb data
  input wire logic pready, // apb ready
  input wire logic pci_bus_rst_n, // bus reset
  input wire logic swap_startup_strap_n, // strap
  input wire logic [1:0] backplane_speed_strap, // speed code
  input wire logic speed66_enable_pin, // 66 pin
  input wire logic insertion_event_n_o, // event value
  input wire logic insertion_event_n_oe, // event enable
  input wire logic swap_indicator_led, // led
  input wire logic cfg_retry_all, // retry all
  input wire logic cfg_no_claim, // no claim
  input wire logic pcix_mode, // pci-x mode
  input wire hssc_pkg::hssc_freq_t bus_freq // frequency
);
  logic wr_ctrl, wr_istat, wd0;
  assign wr_ctrl = psel && penable && pwrite && pready && paddr == `HSSC_OFS_CTRL;
  assign wr_istat = psel && penable && pwrite && pready && paddr == `HSSC_OFS_ISTAT;
  assign wd0 = pwdata[`HSSC_CTRL_LED];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_hs_rel;
    $rose(pci_bus_rst_n) && !swap_startup_strap_n;
  endsequence
  property p_od_low;
    insertion_event_n_oe |-> !insertion_event_n_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("event line driven high");
  property p_cfg_excl;
    !(cfg_retry_all && cfg_no_claim);
  endproperty
  a_cfg_excl: assert property (p_cfg_excl) else $error("retry and no claim");
  property p_freq_mode;
    pcix_mode ? bus_freq != hssc_pkg::HSSC_F33 : bus_freq inside {hssc_pkg::HSSC_F33,
      hssc_pkg::HSSC_F66};
  endproperty
  a_freq_mode: assert property (p_freq_mode) else $error("bad mode speed");
  property p_conv;
    s_hs_rel ##0 backplane_speed_strap == 2'h3 |-> ##5 !pcix_mode &&
      bus_freq == {1'b0, speed66_enable_pin};
  endproperty
  a_conv: assert property (p_conv) else $error("conventional mode wrong");
  property p_xmode;
    s_hs_rel ##0 backplane_speed_strap != 2'h3 |-> ##5 pcix_mode &&
      bus_freq == 2'h3 - backplane_speed_strap;
  endproperty
  a_xmode: assert property (p_xmode) else $error("pci-x mode wrong");
  property p_hold;
    pci_bus_rst_n [*6] |-> $stable(bus_freq) && $stable(pcix_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved after capture");
  property p_led;
    $changed(swap_indicator_led) |-> $past(wr_ctrl) && swap_indicator_led == $past(wd0);
  endproperty
  a_led: assert property (p_led) else $error("led moved without write");
  property p_evt_clr;
    $fell(insertion_event_n_oe) |-> $past(wr_istat) || $past(wr_istat, 2);
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("event released early");
endmodule
bind hssc_top hssc_assertions #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pci_bus_rst_n(pci_bus_rst_n),
  .swap_startup_strap_n(swap_startup_strap_n), .backplane_speed_strap(backplane_speed_strap),
  .speed66_enable_pin(speed66_enable_pin), .insertion_event_n_o(insertion_event_n_o),
  .insertion_event_n_oe(insertion_event_n_oe), .swap_indicator_led(swap_indicator_led),
  .cfg_retry_all(cfg_retry_all), .cfg_no_claim(cfg_no_claim), .pcix_mode(pcix_mode),
  .bus_freq(bus_freq));
`default_nettype wire

// *** bench/test_hot_swap_startup_control.sv ***
/*
  Self-checking bench of the hot-swap startup control block.
  Assumes the checker is bound from its own file and the partner model.
*/
`default_nettype none
`include "hssc_cfg.svh"
module test_hot_swap_startup_control;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DB = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, led, irq, m;
  logic rst_n, strap_n, m66, latch, ev_o, ev_oe, retry_all, no_claim, pcix;
  logic [`HSSC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] speed, ef, cd;
  logic [3:0] init_mode;
  hssc_pkg::hssc_freq_t freq;
  wire logic ev_line;
  logic [32:0] exp_q[$];
  int err_total, total_checks, g;
  hssc_top #(.DEBOUNCE_CYCLES(DB)) uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pci_bus_rst_n(rst_n), .swap_startup_strap_n(strap_n),
    .backplane_speed_strap(speed), .speed66_enable_pin(m66), .ejector_latch_state(latch),
    .init_mode_field(init_mode), .insertion_event_n_o(ev_o), .insertion_event_n_oe(ev_oe),
    .swap_indicator_led(led), .cfg_retry_all(retry_all), .cfg_no_claim(no_claim),
    .pcix_mode(pcix), .bus_freq(freq), .irq(irq));
  hssc_partner #(.SETTLE(8)) bp (
    .pclk(pclk), .ev_o(ev_o), .ev_oe(ev_oe), .bus_rst_n(rst_n), .strap_n(strap_n),
    .speed(speed), .m66(m66), .latch(latch), .event_line(ev_line));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // port checks read pre-edge values; callers sit one edge past the launch
  task automatic chk1(input logic s, input logic e);
    check({32'h0000_0000, s}, {32'h0000_0000, e});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0000_0000, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task automatic summarize();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (4000) @(posedge pclk);
    err_total++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    init_mode = 4'hf;
    err_total = 0;
    total_checks = 0;
    void'($urandom(61067));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`HSSC_OFS_CTRL, 33'h0_0000_0000);
    rd(`HSSC_OFS_BSTAT, 33'h0_000f_0001);
    rd(`HSSC_OFS_ISTAT, 33'h0_0000_0000);
    rd(`HSSC_OFS_IMASK, 33'h0_0000_0000);
    wr(12'h010, $urandom());
    rd(12'h010, 33'h1_0000_0000);
    $display("reset test done");
    wr(`HSSC_OFS_CTRL, 32'h0000_0001);
    chk1(led, 1'b1);
    rd(`HSSC_OFS_CTRL, 33'h0_0000_0001);
    wr(`HSSC_OFS_CTRL, 32'h0000_0000);
    chk1(led, 1'b0);
    $display("led test done");
    wr(`HSSC_OFS_BSTAT, 32'h0000_0004);
    for (int c = 0; c < 4; c++) begin
      cd = 2'(c);
      m = 1'($urandom());
      ef = (cd == 2'h3) ? {1'b0, m} : 2'h3 - cd;
      bp.bus_reset(1'b0, cd, m);
      rd(`HSSC_OFS_BSTAT, {13'h0000, 2'h3, cd, 11'h000, cd != 2'h3, 4'h6});
      check({31'h0000_0000, freq}, {31'h0000_0000, ef});
      chk1(no_claim, 1'b1);
      chk1(retry_all, 1'b0);
      rd(`HSSC_OFS_ISTAT, 33'h0_0000_0005);
      chk1(ev_line, 1'b0);
      chk1(irq, 1'b0);
      wr(`HSSC_OFS_ISTAT, 32'h0000_0007);
      chk1(ev_line, 1'b1);
    end
    $display("speed code test done");
    wr(`HSSC_OFS_IMASK, 32'h0000_0002);
    g = 1 + int'($urandom() % 2);
    bp.move_latch(1'b1, g);
    bp.move_latch(1'b0, DB + 6);
    rd(`HSSC_OFS_ISTAT, 33'h0_0000_0000);
    bp.move_latch(1'b1, DB + 6);
    rd(`HSSC_OFS_BSTAT, 33'h0_000f_000e);
    rd(`HSSC_OFS_ISTAT, 33'h0_0000_0002);
    chk1(irq, 1'b1);
    chk1(ev_line, 1'b0);
    wr(`HSSC_OFS_ISTAT, 32'h0000_0002);
    chk1(irq, 1'b0);
    bp.move_latch(1'b0, DB + 6);
    rd(`HSSC_OFS_ISTAT, 33'h0_0000_0001);
    chk1(irq, 1'b0);
    wr(`HSSC_OFS_ISTAT, 32'h0000_0001);
    $display("ejector test done");
    m = 1'($urandom());
    bp.bus_reset(1'b1, 2'($urandom()), m);
    rd(`HSSC_OFS_BSTAT, 33'h0_000f_0005);
    check({31'h0000_0000, freq}, {31'h0000_0000, 1'b0, m});
    chk1(retry_all, 1'b1);
    chk1(no_claim, 1'b0);
    rd(`HSSC_OFS_ISTAT, 33'h0_0000_0004);
    chk1(ev_line, 1'b1);
    wr(`HSSC_OFS_BSTAT, 32'h0000_0000);
    chk1(retry_all, 1'b0);
    $display("non hot-swap test done");
    summarize();
  end
endmodule
`default_nettype wire
